// >>> rtl/nfc_pkg.sv
// Package of constants and types for the NAND command sequencer controller
package nfc_pkg;

	// Command codes for command cycles; CMD_COLCHG, CMD_PROG_MULT, CMD_PROG_CACH and CMD_STATUS2 are never sent
	localparam logic [7:0] CMD_READ      = 8'h00;
	localparam logic [7:0] CMD_READ_GO   = 8'h30;
	localparam logic [7:0] CMD_PROG      = 8'h80;
	localparam logic [7:0] CMD_COLCHG    = 8'h85;
	localparam logic [7:0] CMD_PROG_GO   = 8'h10;
	localparam logic [7:0] CMD_PROG_MULT = 8'h11;
	localparam logic [7:0] CMD_PROG_CACH = 8'h15;
	localparam logic [7:0] CMD_ERASE     = 8'h60;
	localparam logic [7:0] CMD_ERASE_GO  = 8'hd0;
	localparam logic [7:0] CMD_STATUS    = 8'h70;
	localparam logic [7:0] CMD_STATUS2   = 8'h71;
	localparam logic [7:0] CMD_RESET     = 8'hff;

	// Status byte fields
	localparam int STAT_FAIL  = 0;
	localparam int STAT_READY = 6;
	localparam logic [7:0] BAD_MARK = 8'h00;

	// Software register offsets (word index on the command port)
	localparam logic [3:0] REG_CTRL   = 4'h0;
	localparam logic [3:0] REG_ADDR   = 4'h1;
	localparam logic [3:0] REG_DATA   = 4'h2;
	localparam logic [3:0] REG_STATUS = 4'h3;
	localparam logic [3:0] REG_RDATA  = 4'h4;
	localparam logic [3:0] REG_BADLO  = 4'h5;
	localparam logic [3:0] REG_LAST   = 4'h6;

	// Operation codes written to the control register
	localparam logic [2:0] OP_RESET  = 3'h0;
	localparam logic [2:0] OP_STATUS = 3'h1;
	localparam logic [2:0] OP_READ   = 3'h2;
	localparam logic [2:0] OP_PROG   = 3'h3;
	localparam logic [2:0] OP_ERASE  = 3'h4;
	localparam logic [2:0] OP_RDNEXT = 3'h5;
	localparam logic [2:0] OP_RESUME = 3'h6;

	// Geometry and limits
	localparam int ADDR_CYCLES  = 5;
	localparam int ROW_CYCLES   = 3;
	localparam int PAGE_BITS    = 6;
	localparam int BLOCK_BITS   = 12;
	localparam int BAD_SLOTS    = 16;
	localparam logic [2:0] MAX_PARTIAL = 3'h4;
	localparam logic [7:0] RESET_CTRL  = 8'h00;

	// Pin strobe timing
	localparam int CLK_NS      = 50;
	localparam int STROBE_NS   = 25;
	localparam int STROBE_CYC  = (STROBE_NS + CLK_NS - 1) / CLK_NS;

	typedef enum logic [6:0] {
		ST_IDLE  = 7'b0000001,
		ST_CMD   = 7'b0000010,
		ST_ADDR  = 7'b0000100,
		ST_WDATA = 7'b0001000,
		ST_RDATA = 7'b0010000,
		ST_WAIT  = 7'b0100000,
		ST_NEXT  = 7'b1000000
	} nfc_state_t;

endpackage : nfc_pkg

// >>> rtl/nfc_strobe.sv
// Pin cycle engine: drives one command, address, write or read cycle
`timescale 1ns/100ps
module nfc_strobe (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       reset_n,
	input  wire logic       clkEn,
	// Request
	input  wire logic       start,
	input  wire logic [1:0] kind,
	input  wire logic [7:0] dataOut,
	// Answer
	output logic            done,
	output logic [7:0]      dataIn,
	// Pins
	output logic            cmdLatch,
	output logic            addrLatch,
	output logic            writeEn_n,
	output logic            readEn_n,
	output logic [7:0]      ioOut,
	output logic            ioOe,
	input  wire logic [7:0] ioIn
);

	logic       busy;
	logic [1:0] phase;
	logic [1:0] held;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			busy      <= 1'b0;
			phase     <= 2'h0;
			held      <= 2'h0;
			done      <= 1'b0;
			dataIn    <= 8'h00;
			cmdLatch  <= 1'b0;
			addrLatch <= 1'b0;
			writeEn_n <= 1'b1;
			readEn_n  <= 1'b1;
			ioOut     <= 8'h00;
			ioOe      <= 1'b0;
		end else if (clkEn) begin
			done <= 1'b0;
			if (!busy && start) begin
				busy      <= 1'b1;
				phase     <= 2'h0;
				held      <= kind;
				cmdLatch  <= (kind == 2'h0);
				addrLatch <= (kind == 2'h1);
				ioOut     <= dataOut;
				ioOe      <= (kind != 2'h3);
				writeEn_n <= (kind == 2'h3);
				readEn_n  <= (kind != 2'h3);
			end else if (busy) begin
				phase <= phase + 2'h1;
				if (phase == 2'(nfc_pkg::STROBE_CYC - 1)) begin
					writeEn_n <= 1'b1;
					readEn_n  <= 1'b1;
					if (held == 2'h3) begin
						dataIn <= ioIn;
					end
				end else if (phase == 2'(nfc_pkg::STROBE_CYC)) begin
					busy      <= 1'b0;
					done      <= 1'b1;
					cmdLatch  <= 1'b0;
					addrLatch <= 1'b0;
					ioOe      <= 1'b0;
				end
			end
		end
	end

endmodule : nfc_strobe

// >>> rtl/nfc_host.sv
// Host controller that sequences commands to an 8-bit NAND flash
`timescale 1ns/100ps
// How it works
// - Until first ready, only reset or status ops are issued.
// - Only codes from the defined command set are ever sent.
// - While busy, only status or reset are sent; others refused.
// - After serial input only confirm-program or reset are sent.
// - Programs in a block must go to ascending page addresses; checked only against the last accepted program.
// - Shared ready line, not the status byte, ends each wait and clears opBusy.
// - At most four partial programs per page; counted only for the last page programmed.
// - A block whose marker byte reads zero is classed bad.
// - Erase to a block recorded bad is refused.
// - Failed program or erase marks the block bad.
// - Failed program flag tells software to rewrite elsewhere.
// - Software applies 8-bit per 512-byte correction to read data.
module nfc_host (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire logic        clkEn,
	// Software port
	input  wire logic [3:0]  regAddr,
	input  wire logic [31:0] regWdata,
	input  wire logic        regWrite,
	input  wire logic        regRead,
	output logic [31:0]      regRdata,
	// Flash pins
	output logic             chipEn_n,
	output logic             cmdLatch,
	output logic             addrLatch,
	output logic             writeEn_n,
	output logic             readEn_n,
	output logic             writeProt_n,
	output logic [7:0]       ioOut,
	output logic             ioOe,
	input  wire logic [7:0]  ioIn,
	input  wire logic        ready_busy_output
);

	localparam int BLKW = nfc_pkg::BLOCK_BITS;
	nfc_pkg::nfc_state_t state;
	logic [7:0]  ctrl;
	logic [39:0] addr;
	logic [7:0]  wdata;
	logic [7:0]  rdata;
	logic [7:0]  lastStatus;
	logic        initDone;
	logic        opBusy;
	logic        devBusy;
	logic        refused;
	logic        progFail;
	logic        eraseFail;
	logic        badFound;
	logic        readMode;
	logic        statusMode;
	logic [2:0]  op;
	logic [2:0]  addrCnt;
	logic [15:0] wordCnt;
	logic [15:0] wordLen;
	logic [7:0]  cmdQ [0:1];
	logic        secondCmd;
	logic [BLKW-1:0] badTab [0:nfc_pkg::BAD_SLOTS-1];
	logic [nfc_pkg::BAD_SLOTS-1:0] badValid;
	logic [BLKW-1:0] progBlock;
	logic [nfc_pkg::PAGE_BITS-1:0] progPage;
	logic        progPageValid;
	logic [2:0]  partialCnt;
	logic        stStart;
	logic [1:0]  stKind;
	logic [7:0]  stData;
	logic        stDone;
	logic [7:0]  stIn;
	logic        seOut;

	// Block and page fields of the row address
	function automatic logic [BLKW-1:0] blockOf(input logic [39:0] a);
		blockOf = a[16 + nfc_pkg::PAGE_BITS +: BLKW];
	endfunction : blockOf

	function automatic logic [nfc_pkg::PAGE_BITS-1:0] pageOf(
		input logic [39:0] a);
		pageOf = a[16 +: nfc_pkg::PAGE_BITS];
	endfunction : pageOf

	function automatic logic isBad(input logic [BLKW-1:0] b,
		input logic [nfc_pkg::BAD_SLOTS-1:0] v);
		isBad = 1'b0;
		for (int i = 0; i < nfc_pkg::BAD_SLOTS; i++) begin
			if (v[i] && badTab[i] == b) begin
				isBad = 1'b1;
			end
		end
	endfunction : isBad

	assign devBusy = !initDone || opBusy;

	nfc_strobe u_strobe (
		.clk_sys   (clk_sys),
		.reset_n   (reset_n),
		.clkEn     (clkEn),
		.start     (stStart),
		.kind      (stKind),
		.dataOut   (stData),
		.done      (stDone),
		.dataIn    (stIn),
		.cmdLatch  (cmdLatch),
		.addrLatch (addrLatch),
		.writeEn_n (writeEn_n),
		.readEn_n  (readEn_n),
		.ioOut     (ioOut),
		.ioOe      (ioOe),
		.ioIn      (ioIn)
	);

	// Software writes and op acceptance
	logic opGo;
	logic [2:0] opReq;
	assign opReq = regWdata[2:0];
	always_comb begin
		opGo = 1'b0;
		if (regWrite && regAddr == nfc_pkg::REG_CTRL && state ==
			nfc_pkg::ST_IDLE) begin
			case (opReq)
				nfc_pkg::OP_RESET,
				nfc_pkg::OP_STATUS: opGo = 1'b1;
				nfc_pkg::OP_PROG:   opGo = !devBusy && regWdata[3] &&
					(!progPageValid || blockOf(addr) != progBlock ||
					pageOf(addr) > progPage ||
					(pageOf(addr) == progPage &&
					partialCnt < nfc_pkg::MAX_PARTIAL));
				nfc_pkg::OP_ERASE:  opGo = !devBusy && regWdata[3] &&
					!isBad(blockOf(addr), badValid);
				nfc_pkg::OP_READ,
				nfc_pkg::OP_RDNEXT: opGo = !devBusy;
				nfc_pkg::OP_RESUME: opGo = statusMode && readMode;
				default:            opGo = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			ctrl        <= nfc_pkg::RESET_CTRL;
			addr        <= 40'h0;
			wdata       <= 8'hff;
			writeProt_n <= 1'b0;
			wordLen     <= 16'h0;
			refused     <= 1'b0;
		end else if (clkEn) begin
			if (regWrite) begin
				case (regAddr)
					nfc_pkg::REG_CTRL: begin
						ctrl        <= regWdata[7:0];
						writeProt_n <= regWdata[3];
						wordLen     <= regWdata[31:16];
						refused     <= !opGo;
					end
					nfc_pkg::REG_ADDR: addr <= {regWdata[23:0], 16'h0};
					nfc_pkg::REG_DATA: wdata <= regWdata[7:0];
					default: ;
				endcase
			end
		end
	end

	// Sequencer
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state     <= nfc_pkg::ST_IDLE;
			op        <= nfc_pkg::OP_RESET;
			stStart   <= 1'b0;
			stKind    <= 2'h0;
			stData    <= 8'h00;
			addrCnt   <= 3'h0;
			wordCnt   <= 16'h0;
			secondCmd <= 1'b0;
			rdata     <= 8'h00;
			chipEn_n  <= 1'b1;
			seOut     <= 1'b0;
		end else if (clkEn) begin
			stStart <= 1'b0;
			case (state)
				nfc_pkg::ST_IDLE: begin
					if (opGo) begin
						op        <= opReq;
						chipEn_n  <= 1'b0;
						secondCmd <= 1'b0;
						addrCnt   <= 3'h0;
						wordCnt   <= 16'h0;
						// Read next is a bare read pulse, no command
						state     <= (opReq == nfc_pkg::OP_RDNEXT) ?
							nfc_pkg::ST_RDATA : nfc_pkg::ST_CMD;
					end
				end
				nfc_pkg::ST_CMD: begin
					stStart <= 1'b1;
					stKind  <= 2'h0;
					state   <= nfc_pkg::ST_NEXT;
					case (op)
						nfc_pkg::OP_RESET:  stData <= nfc_pkg::CMD_RESET;
						nfc_pkg::OP_STATUS: stData <= nfc_pkg::CMD_STATUS;
						nfc_pkg::OP_READ:   stData <= secondCmd ?
							nfc_pkg::CMD_READ_GO : nfc_pkg::CMD_READ;
						nfc_pkg::OP_PROG:   stData <= secondCmd ?
							nfc_pkg::CMD_PROG_GO : nfc_pkg::CMD_PROG;
						nfc_pkg::OP_ERASE:  stData <= secondCmd ?
							nfc_pkg::CMD_ERASE_GO : nfc_pkg::CMD_ERASE;
						nfc_pkg::OP_RESUME: stData <= nfc_pkg::CMD_READ;
						default:            stData <= nfc_pkg::CMD_RESET;
					endcase
				end
				nfc_pkg::ST_NEXT: begin
					if (stDone) begin
						if (secondCmd || op == nfc_pkg::OP_RESET) begin
							state <= nfc_pkg::ST_WAIT;
						end else if (op == nfc_pkg::OP_STATUS ||
							op == nfc_pkg::OP_RDNEXT) begin
							state <= nfc_pkg::ST_RDATA;
						end else if (op == nfc_pkg::OP_RESUME) begin
							chipEn_n <= 1'b1;
							state    <= nfc_pkg::ST_IDLE;
						end else begin
							state <= nfc_pkg::ST_ADDR;
						end
					end
				end
				nfc_pkg::ST_ADDR: begin
					if (!stStart && (addrCnt == 3'h0 || stDone)) begin
						if (addrCnt == 3'(nfc_pkg::ADDR_CYCLES)) begin
							secondCmd <= 1'b1;
							state <= (op == nfc_pkg::OP_PROG) ?
								nfc_pkg::ST_WDATA : nfc_pkg::ST_CMD;
						end else begin
							stStart <= 1'b1;
							stKind  <= 2'h1;
							stData  <= (op == nfc_pkg::OP_ERASE) ?
								addr[16 + 8*addrCnt[1:0] +: 8] :
								addr[8*addrCnt +: 8];
							addrCnt <= (op == nfc_pkg::OP_ERASE &&
								addrCnt == 3'(nfc_pkg::ROW_CYCLES - 1)) ?
								3'(nfc_pkg::ADDR_CYCLES) : addrCnt + 3'h1;
						end
					end
				end
				nfc_pkg::ST_WDATA: begin
					if (!stStart && (wordCnt == 16'h0 || stDone)) begin
						if (wordCnt == wordLen) begin
							state <= nfc_pkg::ST_CMD;
						end else begin
							stStart <= 1'b1;
							stKind  <= 2'h2;
							stData  <= wdata;
							wordCnt <= wordCnt + 16'h1;
						end
					end
				end
				nfc_pkg::ST_RDATA: begin
					if (!seOut) begin
						stStart <= 1'b1;
						stKind  <= 2'h3;
						seOut   <= 1'b1;
					end else if (stDone) begin
						seOut    <= 1'b0;
						rdata    <= stIn;
						chipEn_n <= 1'b1;
						state    <= nfc_pkg::ST_IDLE;
					end
				end
				nfc_pkg::ST_WAIT: begin
					if (stStart) begin
					end else if (ready_busy_output && !opBusy) begin
						chipEn_n <= 1'b1;
						state    <= nfc_pkg::ST_IDLE;
					end
				end
				default: state <= nfc_pkg::ST_IDLE;
			endcase
		end
	end

	// Device state tracking
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			initDone   <= 1'b0;
			opBusy     <= 1'b0;
			readMode   <= 1'b0;
			statusMode <= 1'b0;
			lastStatus <= 8'h00;
		end else if (clkEn) begin
			if (state == nfc_pkg::ST_NEXT && stDone) begin
				opBusy <= secondCmd || op == nfc_pkg::OP_RESET;
				case (op)
					nfc_pkg::OP_STATUS: statusMode <= 1'b1;
					nfc_pkg::OP_RESUME: statusMode <= 1'b0;
					nfc_pkg::OP_READ:   begin
						statusMode <= 1'b0;
						readMode   <= secondCmd;
					end
					nfc_pkg::OP_PROG,
					nfc_pkg::OP_ERASE,
					nfc_pkg::OP_RESET:  begin
						statusMode <= 1'b0;
						readMode   <= 1'b0;
					end
					default: ;
				endcase
			end else if (state == nfc_pkg::ST_WAIT && ready_busy_output &&
				!stStart) begin
				opBusy <= 1'b0;
				if (op == nfc_pkg::OP_RESET) begin
					initDone <= 1'b1;
				end
			end
			if (state == nfc_pkg::ST_RDATA && stDone &&
				op == nfc_pkg::OP_STATUS) begin
				lastStatus <= stIn;
				if (stIn[nfc_pkg::STAT_READY]) begin
					initDone <= 1'b1;
				end
			end
		end
	end

	// Result flags, bad block table and page order tracking
	logic badHit;
	assign badHit = (state == nfc_pkg::ST_RDATA && stDone &&
		op == nfc_pkg::OP_RDNEXT && stIn == nfc_pkg::BAD_MARK) ||
		(state == nfc_pkg::ST_RDATA && stDone && op == nfc_pkg::OP_STATUS &&
		stIn[nfc_pkg::STAT_READY] && stIn[nfc_pkg::STAT_FAIL] &&
		progPageValid);
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			progFail      <= 1'b0;
			eraseFail     <= 1'b0;
			badFound      <= 1'b0;
			badValid      <= '0;
			progBlock     <= '0;
			progPage      <= '0;
			progPageValid <= 1'b0;
			partialCnt    <= 3'h0;
			for (int i = 0; i < nfc_pkg::BAD_SLOTS; i++) begin
				badTab[i] <= '0;
			end
		end else if (clkEn) begin
			if (state == nfc_pkg::ST_IDLE && opGo &&
				opReq == nfc_pkg::OP_PROG) begin
				partialCnt <= (progPageValid && pageOf(addr) == progPage &&
					blockOf(addr) == progBlock) ? partialCnt + 3'h1 : 3'h1;
				progBlock     <= blockOf(addr);
				progPage      <= pageOf(addr);
				progPageValid <= 1'b1;
			end
			if (state == nfc_pkg::ST_IDLE && opGo &&
				opReq == nfc_pkg::OP_ERASE) begin
				progBlock     <= blockOf(addr);
				progPageValid <= 1'b0;
			end
			if (state == nfc_pkg::ST_RDATA && stDone &&
				op == nfc_pkg::OP_STATUS && stIn[nfc_pkg::STAT_READY] &&
				stIn[nfc_pkg::STAT_FAIL]) begin
				progFail  <= progPageValid;
				eraseFail <= !progPageValid;
			end else if (regWrite && regAddr == nfc_pkg::REG_STATUS) begin
				progFail  <= progFail & ~regWdata[0];
				eraseFail <= eraseFail & ~regWdata[1];
				badFound  <= badFound & ~regWdata[2];
			end
			if (badHit || (state == nfc_pkg::ST_RDATA && stDone &&
				op == nfc_pkg::OP_STATUS && stIn[nfc_pkg::STAT_READY] &&
				stIn[nfc_pkg::STAT_FAIL])) begin
				badFound <= 1'b1;
				for (int i = nfc_pkg::BAD_SLOTS - 1; i >= 0; i--) begin
					if (!badValid[i]) begin
						badTab[i] <= (op == nfc_pkg::OP_RDNEXT) ?
							blockOf(addr) : progBlock;
					end
				end
				badValid <= badValid | (~badValid & (badValid + 1'b1));
			end
			if (op == nfc_pkg::OP_RESET && state == nfc_pkg::ST_NEXT) begin
				progPageValid <= 1'b0;
			end
		end
	end

	// Read mux, data one cycle after the strobe
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			regRdata <= 32'h0;
		end else if (clkEn) begin
			regRdata <= 32'h0;
			if (regRead) begin
				case (regAddr)
					nfc_pkg::REG_CTRL:   regRdata <= {16'h0, wordLen[15:8],
						ctrl};
					nfc_pkg::REG_ADDR:   regRdata <= {8'h0, addr[39:16]};
					nfc_pkg::REG_DATA:   regRdata <= {24'h0, wdata};
					nfc_pkg::REG_STATUS: regRdata <= {20'h0, refused,
						statusMode, readMode, initDone, devBusy,
						(state == nfc_pkg::ST_IDLE), badFound, eraseFail,
						progFail, 3'h0} >> 3;
					nfc_pkg::REG_RDATA:  regRdata <= {24'h0, rdata};
					nfc_pkg::REG_BADLO:  regRdata <= {16'h0, badValid};
					nfc_pkg::REG_LAST:   regRdata <= {24'h0, lastStatus};
					default:             regRdata <= 32'h0;
				endcase
			end
		end
	end

endmodule : nfc_host

// >>> bench/nfc_host_props.sv
// Checker of the host controller's pin and register behaviour
`timescale 1ns/100ps
module nfc_host_props (
	// Clock and reset
	input wire logic        clk_sys,
	input wire logic        reset_n,
	// Software port
	input wire logic        regRead,
	input wire logic [31:0] regRdata,
	// Flash pins
	input wire logic        chipEn_n,
	input wire logic        cmdLatch,
	input wire logic        addrLatch,
	input wire logic        writeEn_n,
	input wire logic        readEn_n,
	input wire logic        writeProt_n,
	input wire logic [7:0]  ioOut,
	input wire logic        ioOe,
	input wire logic        ready_busy_output
);
	logic [2:0] addrSeen;
	logic [7:0] prevCmd;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);

	sequence cmdStrobe;
		cmdLatch && $fell(writeEn_n);
	endsequence

	// Address cycles since the last command, and that command
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			addrSeen <= 3'h0;
			prevCmd  <= 8'h00;
		end else if (cmdLatch && $fell(writeEn_n)) begin
			addrSeen <= 3'h0;
			prevCmd  <= ioOut;
		end else if (addrLatch && $fell(writeEn_n)) begin
			addrSeen <= addrSeen + 3'h1;
		end
	end

	a_rdata_quiet: assert property (!$past(regRead) |-> regRdata == 32'h0)
		else $error("read data not zero outside the answer cycle");
	a_we_one_cycle: assert property ($fell(writeEn_n) |=> $rose(writeEn_n))
		else $error("write strobe longer than one cycle");
	a_codes_known: assert property (cmdStrobe |->
		ioOut inside {8'h00, 8'h30, 8'h80, 8'h85, 8'h10, 8'h11, 8'h15,
		8'h60, 8'hd0, 8'h70, 8'h71, 8'hff})
		else $error("unknown command code sent");
	a_busy_status_only: assert property (cmdStrobe ##0
		!ready_busy_output |-> ioOut inside {8'h70, 8'h71, 8'hff})
		else $error("command other than status or reset while busy");
	a_wp_for_write: assert property (cmdStrobe ##0
		(ioOut == 8'h80 || ioOut == 8'h60) |-> writeProt_n)
		else $error("program or erase started while protected");
	a_addr_max_five: assert property (addrSeen <= 3'h5)
		else $error("more than five address cycles");
	a_after_input: assert property (cmdStrobe ##0
		(prevCmd == 8'h80) |-> ioOut inside {8'h85, 8'h10, 8'h11, 8'h15,
		8'hff}) else $error("illegal command after serial input");
	a_read_bus_free: assert property (!readEn_n |-> !ioOe && writeEn_n)
		else $error("host drives the bus during a read pulse");
	a_strobe_selects: assert property ((!writeEn_n || !readEn_n) |-> !chipEn_n)
		else $error("strobe without chip enable");
	a_status_pulse: assert property (cmdStrobe ##0
		(ioOut == 8'h70) |-> ##[1:20] !readEn_n)
		else $error("no read pulse after status");
endmodule : nfc_host_props

// >>> bench/nfc_dev_model.sv
// Behavioural model of the flash device facing the host controller
`timescale 1ns/100ps
module nfc_dev_model #(
	parameter int BUSY_CYC = 40
) (
	// Clock for busy timing
	input  wire logic       clk_sys,
	// Pins from the host
	input  wire logic       chipEn_n,
	input  wire logic       cmdLatch,
	input  wire logic       addrLatch,
	input  wire logic       writeEn_n,
	input  wire logic       readEn_n,
	input  wire logic       writeProt_n,
	input  wire logic [7:0] ioOut,
	// Test controls
	input  wire logic       failNext,
	input  wire logic [7:0] markByte,
	// Pins to the host
	output logic [7:0]      devIo,
	output logic            rbLow
);
	int         busyCnt = BUSY_CYC;
	int         addrCnt = 0;
	int         dataCnt = 0;
	int         progDone = 0;
	int         eraseDone = 0;
	logic       statusMode = 1'b0;
	logic       pendProg = 1'b0;
	logic       pendErase = 1'b0;
	logic       wrBusy = 1'b0;
	logic       failed = 1'b0;
	logic [7:0] col = 8'h00;
	logic [7:0] outByte = 8'h00;
	logic [7:0] stat;

	assign stat = {writeProt_n, {2{busyCnt == 0}}, 4'h0, failed};
	assign rbLow = busyCnt != 0;
	assign devIo = (!readEn_n && !chipEn_n) ? outByte : ~outByte;

	always @(posedge clk_sys) begin
		if (busyCnt != 0) busyCnt <= busyCnt - 1;
	end

	always @(posedge writeEn_n) begin
		if (!chipEn_n && cmdLatch) begin
			// Address count restarts only at commands that open an address phase
			if (ioOut inside {8'h00, 8'h60, 8'h80}) addrCnt = 0;
			if (!(ioOut inside {8'h85, 8'h10, 8'h11, 8'h15, 8'hff}))
				pendProg = 1'b0;
			case (ioOut)
				8'hff: begin
					{pendProg, pendErase, statusMode, wrBusy} = 4'h0;
					busyCnt <= 4;
				end
				8'h70, 8'h71: statusMode = 1'b1;
				8'h00: statusMode = 1'b0;
				8'h30: begin
					col = 8'h00;
					busyCnt <= 8;
				end
				8'h80: begin
					pendProg = 1'b1;
					dataCnt = 0;
				end
				8'h60: pendErase = 1'b1;
				8'h10, 8'hd0: begin
					if ((pendProg || pendErase) && writeProt_n) begin
						progDone += pendProg;
						eraseDone += pendErase;
						failed = failNext;
						wrBusy = 1'b1;
						busyCnt <= BUSY_CYC;
					end
					{pendProg, pendErase} = 2'b00;
				end
				default: ;
			endcase
		end else if (!chipEn_n && addrLatch) begin
			addrCnt++;
		end else if (!chipEn_n) begin
			dataCnt++;
		end
	end

	always @(negedge readEn_n) begin
		if (!chipEn_n) outByte = statusMode ? stat : (markByte ^ col);
	end

	always @(posedge readEn_n) begin
		if (!chipEn_n && !statusMode) col++;
	end

	always @(negedge writeProt_n) begin
		if (wrBusy) busyCnt <= 0;
		wrBusy = 1'b0;
	end
endmodule : nfc_dev_model

// >>> bench/nfc_host_tb.sv
// Self-checking testbench of the NAND host controller
`timescale 1ns/100ps
module nfc_host_tb;
	logic        clk_sys = 1'b0;
	logic        reset_n = 1'b0;
	logic        clkEn = 1'b1;
	logic [3:0]  regAddr = 4'h0;
	logic [31:0] regWdata = 32'h0;
	logic        regWrite = 1'b0;
	logic        regRead = 1'b0;
	logic        failNext = 1'b0;
	logic [31:0] regRdata, rd;
	logic        chipEn_n, cmdLatch, addrLatch, writeEn_n, readEn_n;
	logic        writeProt_n, ioOe, rbLow, ready_busy_output;
	logic [7:0]  ioOut, ioIn, devIo;
	int          fails = 0;
	int          checks_done = 0;

	always #25 clk_sys = ~clk_sys;
	assign ready_busy_output = rbLow ? 1'b0 : 1'b1;
	assign ioIn = ioOe ? ioOut : devIo;

	nfc_host dut (.clk_sys(clk_sys), .reset_n(reset_n), .clkEn(clkEn),
		.regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
		.regRead(regRead), .regRdata(regRdata), .chipEn_n(chipEn_n),
		.cmdLatch(cmdLatch), .addrLatch(addrLatch), .writeEn_n(writeEn_n),
		.readEn_n(readEn_n), .writeProt_n(writeProt_n), .ioOut(ioOut),
		.ioOe(ioOe), .ioIn(ioIn), .ready_busy_output(ready_busy_output));
	nfc_dev_model #(.BUSY_CYC(40)) model (.clk_sys(clk_sys),
		.chipEn_n(chipEn_n), .cmdLatch(cmdLatch), .addrLatch(addrLatch),
		.writeEn_n(writeEn_n), .readEn_n(readEn_n), .ioOut(ioOut),
		.writeProt_n(writeProt_n), .failNext(failNext), .markByte(8'h00),
		.devIo(devIo), .rbLow(rbLow));

	task automatic check(input string nm, input logic [31:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic regWr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge clk_sys);
		regWrite <= 1'b0;
	endtask : regWr

	task automatic regRd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk_sys);
		regRead <= 1'b0;
		#1 d = regRdata;
	endtask : regRd

	task automatic op(input logic [2:0] o, input logic wp, input logic [15:0] n);
		regWr(nfc_pkg::REG_CTRL, {n, 12'h0, wp, o});
	endtask : op

	task automatic statBit(input int b, input logic e, input string nm);
		logic [31:0] s;
		regRd(nfc_pkg::REG_STATUS, s);
		check(nm, {31'h0, s[b]}, {31'h0, e});
	endtask : statBit

	task automatic waitIdle;
		logic [31:0] s;
		int          n;
		s = 32'h0;
		n = 0;
		repeat (2) @(posedge clk_sys);
		while (s[3] !== 1'b1 && n < 3000) begin
			regRd(nfc_pkg::REG_STATUS, s);
			n++;
		end
		if (s[3] !== 1'b1) begin
			fails++;
			tally_and_finish;
		end
	endtask : waitIdle

	task automatic tally_and_finish;
		$display("Checks %0d, mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : tally_and_finish

	initial begin
		repeat (4) @(posedge clk_sys);
		reset_n <= 1'b1;
		op(nfc_pkg::OP_READ, 1'b1, 16'h0);
		statBit(8, 1'b1, "refused before reset");
		op(nfc_pkg::OP_RESET, 1'b1, 16'h0);
		waitIdle;
		statBit(5, 1'b1, "initDone");
		op(nfc_pkg::OP_STATUS, 1'b1, 16'h0);
		waitIdle;
		regRd(nfc_pkg::REG_LAST, rd);
		check("status byte", rd, 32'he0);
		regWr(nfc_pkg::REG_ADDR, 32'h81);
		for (int i = 0; i < 4; i++) begin
			op(nfc_pkg::OP_PROG, 1'b1, 16'h4);
			waitIdle;
		end
		check("addr cycles", model.addrCnt, 5);
		check("data bytes", model.dataCnt, 4);
		op(nfc_pkg::OP_PROG, 1'b1, 16'h4);
		statBit(8, 1'b1, "fifth partial");
		regWr(nfc_pkg::REG_ADDR, 32'h80);
		op(nfc_pkg::OP_PROG, 1'b1, 16'h4);
		statBit(8, 1'b1, "page backward");
		check("programs", model.progDone, 4);
		regWr(nfc_pkg::REG_ADDR, 32'hc0);
		op(nfc_pkg::OP_PROG, 1'b0, 16'h4);
		statBit(8, 1'b1, "program protected");
		check("wp pin", {31'h0, writeProt_n}, 32'h0);
		check("protected", model.progDone, 4);
		failNext <= 1'b1;
		op(nfc_pkg::OP_PROG, 1'b1, 16'h4);
		waitIdle;
		op(nfc_pkg::OP_STATUS, 1'b1, 16'h0);
		waitIdle;
		statBit(0, 1'b1, "progFail");
		regRd(nfc_pkg::REG_BADLO, rd);
		check("bad table", rd, 32'h1);
		failNext <= 1'b0;
		op(nfc_pkg::OP_ERASE, 1'b1, 16'h0);
		statBit(8, 1'b1, "erase bad block");
		check("erases", model.eraseDone, 0);
		regWr(nfc_pkg::REG_STATUS, 32'h7);
		statBit(0, 1'b0, "progFail cleared");
		regWr(nfc_pkg::REG_ADDR, 32'h100);
		op(nfc_pkg::OP_ERASE, 1'b1, 16'h0);
		op(nfc_pkg::OP_READ, 1'b1, 16'h0);
		statBit(8, 1'b1, "read while busy");
		waitIdle;
		check("erase addr", model.addrCnt, 3);
		check("erase done", model.eraseDone, 1);
		regWr(nfc_pkg::REG_ADDR, 32'h140);
		op(nfc_pkg::OP_READ, 1'b1, 16'h0);
		waitIdle;
		op(nfc_pkg::OP_RDNEXT, 1'b1, 16'h0);
		waitIdle;
		regRd(nfc_pkg::REG_RDATA, rd);
		check("marker", rd, 32'h0);
		statBit(2, 1'b1, "badFound");
		op(nfc_pkg::OP_STATUS, 1'b1, 16'h0);
		waitIdle;
		statBit(7, 1'b1, "statusMode");
		op(nfc_pkg::OP_RESUME, 1'b1, 16'h0);
		waitIdle;
		op(nfc_pkg::OP_RDNEXT, 1'b1, 16'h0);
		waitIdle;
		regRd(nfc_pkg::REG_RDATA, rd);
		check("resumed byte", rd, 32'h1);
		check("resume addr", model.addrCnt, 0);
		// A write while the clock enable is low must leave no trace
		@(posedge clk_sys);
		clkEn <= 1'b0;
		regWr(nfc_pkg::REG_DATA, 32'h5a);
		clkEn <= 1'b1;
		regRd(nfc_pkg::REG_DATA, rd);
		check("frozen write", rd, 32'hff);
		tally_and_finish;
	end
endmodule : nfc_host_tb

bind nfc_host nfc_host_props u_props (.clk_sys(clk_sys), .reset_n(reset_n),
	.regRead(regRead), .regRdata(regRdata), .chipEn_n(chipEn_n),
	.cmdLatch(cmdLatch), .addrLatch(addrLatch), .writeEn_n(writeEn_n),
	.readEn_n(readEn_n), .writeProt_n(writeProt_n), .ioOut(ioOut),
	.ioOe(ioOe), .ready_busy_output(ready_busy_output));
